// ---- core/scc_clock_control.sv ----
`timescale 1ns/10ps
module scc_clock_control #(
  parameter int ADR_WIDTH = 12,
  parameter int DIV_WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADR_WIDTH-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire scc_pkg::scc_src_s i_osc_tick,
  input wire scc_pkg::scc_src_s i_osc_stable,
  input wire logic i_self_program_enable,
  input wire logic i_power_down,
  output logic o_sys_clk,
  output logic o_sys_tick,
  output logic o_clock_out_pin,
  output logic o_clock_out_oe,
  output logic o_fast_rc_on,
  output logic [1:0] o_ext_source_enable,
  output logic o_xtal_pins_gpio,
  output logic [2:0] o_active_source,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [DIV_WIDTH-1:0] sys_clock_divisor_reg;
  logic [1:0] ext_source_enable_reg;
  logic fast_rc_enable_reg;
  logic switch_fault_flag_reg;
  logic [1:0] source_select_reg;
  logic [7:0] port1_mode_two_reg;
  logic [2:0] cur_src_reg;
  logic [2:0] target_reg;
  scc_pkg::scc_switch_e state_reg;
  scc_pkg::scc_switch_e state_next;
  logic [scc_pkg::NUM_IRQ-1:0] event_reg;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [9:0] reg_index = i_wb_adr[11:2];
  wire bus_req = i_wb_cyc & i_wb_stb;
  wire bus_take = bus_req & o_wb_ack;
  wire lane0_write = bus_take & i_wb_we & i_wb_sel[0];
  wire hit_divisor = (reg_index == scc_pkg::IDX_CLOCK_DIVISOR);
  wire hit_switch = (reg_index == scc_pkg::IDX_CLOCK_SWITCH);
  wire hit_enable = (reg_index == scc_pkg::IDX_CLOCK_SOURCE_ENABLE);
  wire hit_status = (reg_index == scc_pkg::IDX_IRQ_STATUS);
  wire hit_mask = (reg_index == scc_pkg::IDX_IRQ_MASK);
  wire hit_port = (reg_index == scc_pkg::IDX_PORT1_MODE_TWO);
  wire wr_divisor = lane0_write & hit_divisor;
  wire wr_switch = lane0_write & hit_switch;
  wire wr_enable = lane0_write & hit_enable;
  wire wr_status = lane0_write & hit_status;
  wire wr_mask = lane0_write & hit_mask;
  wire wr_port = lane0_write & hit_port;
  wire [7:0] wdata = i_wb_dat[7:0];

  // ----------------------------------------------------------------
  // Source enables and stability
  // ----------------------------------------------------------------
  // Self-programming overrides the enable without touching the stored bit,
  // so the software value comes back by itself once it ends
  wire fast_rc_effective = fast_rc_enable_reg | i_self_program_enable;
  wire fast_rc_stable_read = (i_osc_stable.fast_rc & fast_rc_enable_reg) | i_self_program_enable;
  logic [scc_pkg::NUM_SRC-1:0] src_enabled;
  logic [scc_pkg::NUM_SRC-1:0] src_stable;
  logic [scc_pkg::NUM_SRC-1:0] src_ready;

  assign src_enabled[0] = fast_rc_effective;
  assign src_enabled[1] = 1'b1;
  assign src_enabled[2] = (ext_source_enable_reg == scc_pkg::EXT_LOW_XTAL);
  assign src_enabled[3] = (ext_source_enable_reg == scc_pkg::EXT_HIGH_XTAL);
  assign src_enabled[4] = (ext_source_enable_reg == scc_pkg::EXT_CLOCK_IN);
  assign src_stable = {i_osc_stable.clock_in, i_osc_stable.high_xtal, i_osc_stable.low_xtal,
                       i_osc_stable.slow_rc, fast_rc_stable_read};

  genvar g;
  generate
    for (g = 0; g < scc_pkg::NUM_SRC; g = g + 1) begin : g_ready
      assign src_ready[g] = src_enabled[g] & src_stable[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Source mapping
  // ----------------------------------------------------------------
  function automatic logic [2:0] source_of(input logic [1:0] sel, input logic [1:0] ext);
    logic [2:0] src;
    src = scc_pkg::SRC_NONE;
    case (sel)
      scc_pkg::SEL_FAST_RC: src = scc_pkg::SRC_FAST_RC;
      scc_pkg::SEL_SLOW_RC: src = scc_pkg::SRC_SLOW_RC;
      scc_pkg::SEL_EXTERNAL: begin
        case (ext)
          scc_pkg::EXT_LOW_XTAL: src = scc_pkg::SRC_LOW_XTAL;
          scc_pkg::EXT_HIGH_XTAL: src = scc_pkg::SRC_HIGH_XTAL;
          scc_pkg::EXT_CLOCK_IN: src = scc_pkg::SRC_CLOCK_IN;
          default: src = scc_pkg::SRC_NONE;
        endcase
      end
      default: src = scc_pkg::SRC_NONE;
    endcase
    return src;
  endfunction

  function automatic logic [1:0] ext_code_of(input logic [2:0] src);
    logic [1:0] code;
    code = scc_pkg::EXT_NONE;
    case (src)
      scc_pkg::SRC_LOW_XTAL: code = scc_pkg::EXT_LOW_XTAL;
      scc_pkg::SRC_HIGH_XTAL: code = scc_pkg::EXT_HIGH_XTAL;
      scc_pkg::SRC_CLOCK_IN: code = scc_pkg::EXT_CLOCK_IN;
      default: code = scc_pkg::EXT_NONE;
    endcase
    return code;
  endfunction

  // Reserved select code and an external select with nothing enabled map to none
  wire [2:0] write_target = source_of(wdata[scc_pkg::SW_SEL_HI:scc_pkg::SW_SEL_LO], ext_source_enable_reg);
  wire target_valid = (write_target != scc_pkg::SRC_NONE);
  wire target_enabled = target_valid & src_enabled[write_target];
  wire target_ready = target_valid & src_ready[write_target];
  wire pending_enabled = src_enabled[target_reg];
  wire pending_ready = src_ready[target_reg];

  // ----------------------------------------------------------------
  // Enable write guard
  // ----------------------------------------------------------------
  wire [1:0] new_ext = wdata[scc_pkg::EN_EXT_HI:scc_pkg::EN_EXT_LO];
  wire new_fast = wdata[scc_pkg::EN_FAST_RC];
  wire cur_is_ext = (ext_code_of(cur_src_reg) != scc_pkg::EXT_NONE);
  wire kills_fast = (cur_src_reg == scc_pkg::SRC_FAST_RC) & ~new_fast & ~i_self_program_enable;
  wire kills_ext = cur_is_ext & (new_ext != ext_code_of(cur_src_reg));
  wire enable_refused = wr_enable & (kills_fast | kills_ext);
  wire enable_accept = wr_enable & ~enable_refused;

  // ----------------------------------------------------------------
  // System clock divider
  // ----------------------------------------------------------------
  logic [scc_pkg::NUM_SRC-1:0] tick_vec;
  logic sys_level;
  logic sys_toggle;
  logic sys_boundary;

  assign tick_vec = i_osc_tick;

  // Counting halts in power-down, which freezes the clock; the clock output pin is held low instead
  scc_divider #(
    .DIV_WIDTH(DIV_WIDTH)
  ) u_divider (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_osc_tick(tick_vec[cur_src_reg]),
    .i_run(~i_power_down),
    .i_divisor(sys_clock_divisor_reg),
    .o_level(sys_level),
    .o_toggle(sys_toggle),
    .o_boundary(sys_boundary)
  );

  // ----------------------------------------------------------------
  // Switch sequencer
  // ----------------------------------------------------------------
  wire switch_now = (state_reg == scc_pkg::SW_WAIT_EDGE) & pending_ready & sys_boundary;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scc_pkg::SW_IDLE: begin
        state_next = scc_pkg::SW_IDLE;
      end
      scc_pkg::SW_WAIT_STABLE: begin
        if (!pending_enabled) begin
          state_next = scc_pkg::SW_IDLE;
        end else if (pending_ready) begin
          state_next = scc_pkg::SW_WAIT_EDGE;
        end
      end
      scc_pkg::SW_WAIT_EDGE: begin
        if (!pending_enabled) begin
          state_next = scc_pkg::SW_IDLE;
        end else if (!pending_ready) begin
          state_next = scc_pkg::SW_WAIT_STABLE;
        end else if (sys_boundary) begin
          state_next = scc_pkg::SW_IDLE;
        end
      end
      default: state_next = scc_pkg::SW_IDLE;
    endcase
    // A new select write restarts the sequence from scratch
    if (wr_switch) begin
      if (!target_enabled || write_target == cur_src_reg) begin
        state_next = scc_pkg::SW_IDLE;
      end else if (!target_ready) begin
        state_next = scc_pkg::SW_WAIT_STABLE;
      end else begin
        state_next = scc_pkg::SW_WAIT_EDGE;
      end
    end
  end

  wire target_write_other = write_target != cur_src_reg;
  wire fault_set = wr_switch & (~target_enabled | (target_write_other & ~target_ready));
  wire fault_clear = switch_now | (wr_switch & target_enabled & ~target_write_other);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= scc_pkg::SW_IDLE;
      cur_src_reg <= scc_pkg::SRC_FAST_RC;
      target_reg <= scc_pkg::SRC_FAST_RC;
      switch_fault_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (wr_switch && target_valid) begin
        target_reg <= write_target;
      end
      if (switch_now) begin
        cur_src_reg <= target_reg;
      end
      if (fault_set) begin
        switch_fault_flag_reg <= 1'b1;
      end else if (fault_clear) begin
        switch_fault_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sys_clock_divisor_reg <= scc_pkg::CLOCK_DIVISOR_RESET;
      ext_source_enable_reg <= scc_pkg::CLOCK_SOURCE_ENABLE_RESET[scc_pkg::EN_EXT_HI:scc_pkg::EN_EXT_LO];
      fast_rc_enable_reg <= scc_pkg::CLOCK_SOURCE_ENABLE_RESET[scc_pkg::EN_FAST_RC];
      source_select_reg <= scc_pkg::SOURCE_SELECT_RESET;
      port1_mode_two_reg <= scc_pkg::PORT1_MODE_TWO_RESET;
    end else begin
      if (wr_divisor) begin
        sys_clock_divisor_reg <= wdata;
      end
      if (enable_accept) begin
        ext_source_enable_reg <= new_ext;
        fast_rc_enable_reg <= new_fast;
      end
      if (wr_switch) begin
        source_select_reg <= wdata[scc_pkg::SW_SEL_HI:scc_pkg::SW_SEL_LO];
      end
      if (wr_port) begin
        port1_mode_two_reg <= wdata & scc_pkg::PORT1_MODE_TWO_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [scc_pkg::NUM_IRQ-1:0] irq_status;
  logic [scc_pkg::NUM_IRQ-1:0] irq_mask;
  logic irq_line;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      event_reg <= '0;
    end else begin
      event_reg[scc_pkg::IRQ_SWITCH_DONE] <= switch_now;
      event_reg[scc_pkg::IRQ_SWITCH_FAULT] <= fault_set;
      event_reg[scc_pkg::IRQ_WRITE_IGNORED] <= enable_refused;
    end
  end

  scc_irq_bank #(
    .WIDTH(scc_pkg::NUM_IRQ)
  ) u_irq (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_event(event_reg),
    .i_status_write(wr_status),
    .i_mask_write(wr_mask),
    .i_wdata(wdata[scc_pkg::NUM_IRQ-1:0]),
    .o_status(irq_status),
    .o_mask(irq_mask),
    .o_irq(irq_line)
  );

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // The select field reads back as written, not as the running source
  wire [7:0] rd_enable = {ext_source_enable_reg, fast_rc_effective, 5'h00} | scc_pkg::CLOCK_SOURCE_ENABLE_RESERVED_READ
                         | {7'h00, switch_fault_flag_reg};
  wire [7:0] rd_switch = {i_osc_stable.high_xtal & src_enabled[3], i_osc_stable.low_xtal & src_enabled[2],
                          fast_rc_stable_read, 1'b0, i_osc_stable.clock_in & src_enabled[4],
                          source_select_reg, 1'b0};
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (hit_divisor) begin
      rd_byte = sys_clock_divisor_reg;
    end else if (hit_switch) begin
      rd_byte = rd_switch;
    end else if (hit_enable) begin
      rd_byte = rd_enable;
    end else if (hit_status) begin
      rd_byte = {5'h00, irq_status};
    end else if (hit_mask) begin
      rd_byte = {5'h00, irq_mask};
    end else if (hit_port) begin
      rd_byte = port1_mode_two_reg;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer and pins
  // ----------------------------------------------------------------
  wire clock_out_on = port1_mode_two_reg[scc_pkg::PORT1_MODE_TWO_CLOCK_OUT];

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      o_sys_clk <= 1'b0;
      o_sys_tick <= 1'b0;
      o_clock_out_pin <= 1'b0;
      o_clock_out_oe <= 1'b0;
      o_fast_rc_on <= 1'b1;
      o_ext_source_enable <= 2'h0;
      o_xtal_pins_gpio <= 1'b1;
      o_active_source <= scc_pkg::SRC_FAST_RC;
      o_irq <= 1'b0;
    end else begin
      o_wb_ack <= bus_req & ~o_wb_ack;
      o_wb_dat <= {24'h000000, rd_byte};
      o_sys_clk <= sys_level;
      o_sys_tick <= sys_toggle;
      o_clock_out_pin <= sys_level & clock_out_on & ~i_power_down;
      o_clock_out_oe <= clock_out_on;
      o_fast_rc_on <= fast_rc_effective;
      o_ext_source_enable <= ext_source_enable_reg;
      o_xtal_pins_gpio <= (ext_source_enable_reg == scc_pkg::EXT_NONE);
      o_active_source <= cur_src_reg;
      o_irq <= irq_line;
    end
  end

endmodule

// ---- core/scc_divider.sv ----
`timescale 1ns/10ps
module scc_divider #(
  parameter int DIV_WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_osc_tick,
  input wire logic i_run,
  input wire logic [DIV_WIDTH-1:0] i_divisor,
  output logic o_level,
  output logic o_toggle,
  output logic o_boundary
);

  logic [DIV_WIDTH:0] count_reg;
  logic [DIV_WIDTH-1:0] active_div_reg;
  logic [DIV_WIDTH:0] limit;
  logic [DIV_WIDTH:0] count_inc;
  logic step;
  logic wrap;

  // Zero passes each oscillator edge straight on; N waits 2N edges per phase
  assign limit = (active_div_reg == '0) ? (DIV_WIDTH+1)'(1) : {active_div_reg, 1'b0};
  assign count_inc = count_reg + (DIV_WIDTH+1)'(1);
  assign step = i_osc_tick & i_run;
  assign wrap = step & (count_inc >= limit);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_reg <= '0;
      active_div_reg <= '0;
      o_level <= 1'b0;
      o_toggle <= 1'b0;
      o_boundary <= 1'b0;
    end else begin
      o_toggle <= wrap;
      o_boundary <= wrap & o_level;
      if (wrap) begin
        count_reg <= '0;
        o_level <= ~o_level;
      end else if (step) begin
        count_reg <= count_inc;
      end
      // New ratio only at the end of a high phase, so no phase is cut short
      if (wrap & o_level) begin
        active_div_reg <= i_divisor;
      end
    end
  end

endmodule

// ---- core/scc_irq_bank.sv ----
`timescale 1ns/10ps
module scc_irq_bank #(
  parameter int WIDTH = 3
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [WIDTH-1:0] i_event,
  input wire logic i_status_write,
  input wire logic i_mask_write,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_status,
  output logic [WIDTH-1:0] o_mask,
  output logic o_irq
);

  logic [WIDTH-1:0] clear;

  assign clear = i_status_write ? i_wdata : '0;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_status <= '0;
      o_mask <= '0;
      o_irq <= 1'b0;
    end else begin
      // A new event wins over a write-one-to-clear in the same cycle
      o_status <= (o_status & ~clear) | i_event;
      if (i_mask_write) begin
        o_mask <= i_wdata;
      end
      o_irq <= |(((o_status & ~clear) | i_event) & (i_mask_write ? i_wdata : o_mask));
    end
  end

endmodule

// ---- include/scc_pkg.sv ----
package scc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_CLOCK_DIVISOR = 10'h095;
  localparam logic [9:0] IDX_CLOCK_SWITCH = 10'h096;
  localparam logic [9:0] IDX_CLOCK_SOURCE_ENABLE = 10'h097;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h098;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h099;
  localparam logic [9:0] IDX_PORT1_MODE_TWO = 10'h0B4;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CLOCK_DIVISOR_RESET = 8'h00;
  localparam logic [7:0] CLOCK_SOURCE_ENABLE_RESET = 8'h30;
  localparam logic [7:0] PORT1_MODE_TWO_RESET = 8'h00;
  localparam logic [1:0] SOURCE_SELECT_RESET = 2'h0;
  localparam int EN_EXT_HI = 7;
  localparam int EN_EXT_LO = 6;
  localparam int EN_FAST_RC = 5;
  localparam int EN_FAULT = 0;
  localparam int SW_SEL_HI = 2;
  localparam int SW_SEL_LO = 1;
  localparam int PORT1_MODE_TWO_CLOCK_OUT = 3;
  localparam logic [7:0] CLOCK_SOURCE_ENABLE_RESERVED_READ = 8'h10;
  localparam logic [7:0] PORT1_MODE_TWO_WRITE_MASK = 8'h0F;

  // ----------------------------------------------------------------
  // Source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_FAST_RC = 2'h0;
  localparam logic [1:0] SEL_EXTERNAL = 2'h1;
  localparam logic [1:0] SEL_SLOW_RC = 2'h2;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_LOW_XTAL = 2'h1;
  localparam logic [1:0] EXT_HIGH_XTAL = 2'h2;
  localparam logic [1:0] EXT_CLOCK_IN = 2'h3;
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_SLOW_RC = 3'h1;
  localparam logic [2:0] SRC_LOW_XTAL = 3'h2;
  localparam logic [2:0] SRC_HIGH_XTAL = 3'h3;
  localparam logic [2:0] SRC_CLOCK_IN = 3'h4;
  localparam logic [2:0] SRC_NONE = 3'h7;
  localparam int NUM_SRC = 5;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int NUM_IRQ = 3;
  localparam int IRQ_SWITCH_DONE = 0;
  localparam int IRQ_SWITCH_FAULT = 1;
  localparam int IRQ_WRITE_IGNORED = 2;

  // One bit per oscillator, fast RC in bit 0
  typedef struct packed {
    logic clock_in;
    logic high_xtal;
    logic low_xtal;
    logic slow_rc;
    logic fast_rc;
  } scc_src_s;

  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT_STABLE = 3'b010,
    SW_WAIT_EDGE = 3'b100
  } scc_switch_e;

endpackage

// ---- test/scc_clock_control_bench.sv ----
`timescale 1ns/10ps
module scc_clock_control_bench;
  // --------------------
  // Stimulus and model state
  // --------------------
  localparam logic [9:0] A_DIV = scc_pkg::IDX_CLOCK_DIVISOR;
  localparam logic [9:0] A_SW = scc_pkg::IDX_CLOCK_SWITCH;
  localparam logic [9:0] A_EN = scc_pkg::IDX_CLOCK_SOURCE_ENABLE;
  localparam logic [9:0] A_ST = scc_pkg::IDX_IRQ_STATUS;
  localparam logic [9:0] A_MK = scc_pkg::IDX_IRQ_MASK;
  localparam logic [9:0] A_P1 = scc_pkg::IDX_PORT1_MODE_TWO;
  logic i_mclk = 1'h0;
  logic i_reset_n = 1'h0;
  logic cyc = 1'h0;
  logic we = 1'h0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic spe = 1'h0;
  logic pd = 1'h0;
  scc_pkg::scc_src_s stable = 5'h03;
  scc_pkg::scc_src_s tick = 5'h1F;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, sys_clk, sys_tick, clk_out, clk_oe, rc_on, gpio, irq, b;
  logic [1:0] ext;
  logic [2:0] src;
  int miscompares = 0;
  int total_checks = 0;
  int n, c;
  scc_clock_control u_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_osc_tick(tick),
    .i_osc_stable(stable), .i_self_program_enable(spe), .i_power_down(pd), .o_sys_clk(sys_clk),
    .o_sys_tick(sys_tick), .o_clock_out_pin(clk_out), .o_clock_out_oe(clk_oe), .o_fast_rc_on(rc_on),
    .o_ext_source_enable(ext), .o_xtal_pins_gpio(gpio), .o_active_source(src), .o_irq(irq));
  initial forever #2.5 i_mclk = ~i_mclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    cyc <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge i_mclk);
      k++;
    end while (ack !== 1'h1 && k < 50);
    q = rdat;
    cyc <= 1'h0;
    if (k == 50) chk(32'h0, 32'h1);
  endtask
  task rd(input logic [9:0] idx, input logic [7:0] e);
    bus(1'h0, idx, 8'h00);
    chk(q, {24'h0, e});
  endtask
  // Distance between the last two toggles; the first ones may still use the old divisor
  task period(output int t);
    repeat (4) begin
      t = 0;
      do begin
        @(posedge i_mclk);
        t++;
      end while (sys_tick !== 1'h1 && t < 600);
    end
  endtask
  task toggles(output int t);
    logic p;
    t = 0;
    p = clk_out;
    repeat (8) begin
      @(posedge i_mclk);
      if (clk_out !== p) t++;
      p = clk_out;
    end
  endtask
  task till(input logic [2:0] s);
    int k;
    k = 0;
    while (src !== s && k < 100) begin
      @(posedge i_mclk);
      k++;
    end
    chk(32'(src), 32'(s));
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Whole run is a few thousand cycles; 20000 leaves ample margin
  initial begin
    #100000;
    miscompares++;
    end_of_test;
  end
  initial begin
    void'($urandom(67));
    repeat (3) @(posedge i_mclk);
    i_reset_n <= 1'h1;
    rd(A_DIV, 8'h00);
    rd(A_EN, 8'h30);
    rd(A_P1, 8'h00);
    rd(10'h0A0, 8'h00);
    chk(32'(gpio), 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 0 : (i == 1) ? 1 : (i == 3) ? 255 : 2 + $urandom % 250;
      bus(1'h1, A_DIV, 8'(n));
      period(c);
      chk(32'(c), 32'(n == 0 ? 1 : 2 * n));
      rd(A_DIV, 8'(n));
    end
    bus(1'h1, A_DIV, 8'h00);
    period(c);
    chk(32'(c), 32'h1);
    $display("test divisor done");
    n = ($urandom | 8) & 255;
    bus(1'h1, A_P1, 8'(n));
    rd(A_P1, 8'(n & 15));
    toggles(c);
    chk(32'({clk_oe, 7'(c)}), 32'h88);
    pd <= 1'h1;
    repeat (3) @(posedge i_mclk);
    b = sys_clk;
    toggles(c);
    chk(32'({sys_clk, 7'(c)}), 32'({b, 7'h0}));
    pd <= 1'h0;
    bus(1'h1, A_P1, 8'h00);
    repeat (2) @(posedge i_mclk);
    toggles(c);
    chk(32'({clk_oe, 7'(c)}), 32'h0);
    $display("test clock output done");
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, A_EN, 8'(i * 64 + 32));
      repeat (2) @(posedge i_mclk);
      chk(32'({ext, gpio}), 32'(i * 2 + (i == 0)));
    end
    bus(1'h1, A_EN, 8'hA0);
    bus(1'h1, A_SW, 8'h02);
    rd(A_EN, 8'hB1);
    chk(32'(src), 32'h0);
    stable.high_xtal <= 1'h1;
    till(3'h3);
    rd(A_EN, 8'hB0);
    rd(A_SW, 8'hA2);
    bus(1'h1, A_EN, 8'h20);
    rd(A_EN, 8'hB0);
    bus(1'h1, A_EN, 8'h80);
    rd(A_EN, 8'h90);
    spe <= 1'h1;
    rd(A_EN, 8'hB0);
    chk(32'(rc_on), 32'h1);
    spe <= 1'h0;
    rd(A_EN, 8'h90);
    chk(32'(rc_on), 32'h0);
    bus(1'h1, A_SW, 8'h00);
    rd(A_EN, 8'h91);
    rd(A_SW, 8'h80);
    chk(32'(src), 32'h3);
    bus(1'h1, A_SW, 8'h04);
    till(3'h1);
    rd(A_EN, 8'h90);
    $display("test switching done");
    rd(A_ST, 8'h07);
    bus(1'h1, A_MK, 8'h02);
    bus(1'h1, A_ST, 8'h05);
    rd(A_ST, 8'h02);
    chk(32'(irq), 32'h1);
    bus(1'h1, A_ST, 8'h02);
    rd(A_ST, 8'h00);
    chk(32'(irq), 32'h0);
    $display("test interrupt done");
    end_of_test;
  end
endmodule

// ---- test/scc_clock_control_properties.sv ----
`timescale 1ns/10ps
module scc_clock_control_properties (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_self_program_enable,
  input wire logic i_power_down,
  input wire logic o_wb_ack,
  input wire logic o_sys_clk,
  input wire logic o_clock_out_pin,
  input wire logic o_clock_out_oe,
  input wire logic o_fast_rc_on,
  input wire logic [1:0] o_ext_source_enable,
  input wire logic o_xtal_pins_gpio,
  input wire logic [2:0] o_active_source,
  input wire logic o_irq
);
  // --------------------
  // Port relations
  // --------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered in the next cycle");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  AST_ACK_IDLE: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without a request");
  AST_GPIO: assert property (o_xtal_pins_gpio == (o_ext_source_enable == 2'h0))
    else $error("crystal pin release disagrees with enable field");
  AST_FORCE: assert property (i_self_program_enable [*2] |-> o_fast_rc_on)
    else $error("fast oscillator off during self-programming");
  AST_OUT_OFF: assert property (!o_clock_out_oe [*2] |-> !o_clock_out_pin)
    else $error("clock output active while disabled");
  AST_PD_PIN: assert property (i_power_down [*2] |-> !o_clock_out_pin)
    else $error("clock output active in power-down");
  // Two register stages may still land after power-down rises
  AST_PD_FREEZE: assert property (i_power_down [*3] |-> $stable(o_sys_clk))
    else $error("system clock moves in power-down");
  AST_SRC_LEGAL: assert property (o_active_source <= 3'h4)
    else $error("running source code out of range");
  cover property (o_irq);
  cover property ($changed(o_active_source));
  cover property (o_clock_out_pin && o_clock_out_oe);
endmodule
bind scc_clock_control scc_clock_control_properties u_props (.*);
